/* core/nvs_pkg.sv */
package nvs_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;

  // ----------------------------------------------------------------
  // documented times, in their own units (all are maxima)
  // ----------------------------------------------------------------
  localparam int POWERUP_RESTORE_TIME_MS = 20;
  localparam int SAVE_CYCLE_TIME_MS      = 8;
  localparam int WRITE_GRACE_TIME_NS     = 25;
  localparam int SLEEP_EXIT_TIME_MS      = 20;
  localparam int SLEEP_ENTRY_TIME_MS     = 8;
  localparam int STANDBY_ENTRY_TIME_US   = 100;
  localparam int SOFT_RESTORE_TIME_US    = 600;
  localparam int SOFT_COMMAND_TIME_US    = 500;

  // ----------------------------------------------------------------
  // cycle counts: maxima round down, never below one cycle
  // ----------------------------------------------------------------
  function automatic int ns_to_cyc(input int t_ns);
    int c;
    // divide by whole ns per cycle: t_ns * 1000 would overflow for ms times
    c = t_ns / (CLK_PERIOD_PS / 1000);
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POWERUP_RESTORE_CYC = ns_to_cyc(POWERUP_RESTORE_TIME_MS * 1000000);
  localparam int SAVE_CYCLE_CYC      = ns_to_cyc(SAVE_CYCLE_TIME_MS * 1000000);
  localparam int WRITE_GRACE_CYC     = ns_to_cyc(WRITE_GRACE_TIME_NS);
  localparam int SLEEP_EXIT_CYC      = ns_to_cyc(SLEEP_EXIT_TIME_MS * 1000000);
  localparam int SLEEP_ENTRY_CYC     = ns_to_cyc(SLEEP_ENTRY_TIME_MS * 1000000);
  localparam int STANDBY_ENTRY_CYC   = ns_to_cyc(STANDBY_ENTRY_TIME_US * 1000);
  localparam int SOFT_RESTORE_CYC    = ns_to_cyc(SOFT_RESTORE_TIME_US * 1000);
  localparam int SOFT_COMMAND_CYC    = ns_to_cyc(SOFT_COMMAND_TIME_US * 1000);

  // standby is entered one cycle more than this count after the idle level is seen
  localparam int STANDBY_LAT_CYC     = 4;

  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // soft commands
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_SAVE    = 2'h0;
  localparam logic [1:0] CMD_RECALL  = 2'h1;
  localparam logic [1:0] CMD_SLEEP   = 2'h2;

  typedef enum logic [3:0] {
    ST_PUREC, ST_READY, ST_SAVE, ST_RECALL, ST_SLEEP_IN,
    ST_SLEEP, ST_WAKE, ST_GRACE, ST_AUTO, ST_DOWN
  } nvs_state_t;

endpackage

/* core/nvs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface nvs_link_if;
  logic       cmd_tgl;
  logic [1:0] cmd_code;
  logic       write_tgl;
  logic       wake_tgl;
  modport tx (output cmd_tgl, output cmd_code, output write_tgl, output wake_tgl);
  modport rx (input cmd_tgl, input cmd_code, input write_tgl, input wake_tgl);
endinterface
`default_nettype wire

/* core/nvs_link_side.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_link_side (
  // link clock and supply-good reset
  input  wire logic scl,
  input  wire logic reset_n,
  // decoded strobes from the protocol engine, scl domain
  input  wire logic       cmd_stb,
  input  wire logic [1:0] cmd_code,
  input  wire logic       sram_wr_stb,
  input  wire logic       addr_match_stb,
  // toward the core domain
  nvs_link_if.tx          link
);

  logic       rst_meta_reg;
  logic       rst_n_reg;
  logic       cmd_tgl_reg;
  logic       cmd_tgl_next;
  logic [1:0] code_reg;
  logic [1:0] code_next;
  logic       wr_tgl_reg;
  logic       wr_tgl_next;
  logic       wake_tgl_reg;
  logic       wake_tgl_next;

  // ----------------------------------------------------------------
  // reset release on scl
  // ----------------------------------------------------------------
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // events become toggles; code is held until the next command
  // ----------------------------------------------------------------
  always_comb begin
    cmd_tgl_next  = cmd_tgl_reg ^ cmd_stb;
    code_next     = cmd_stb ? cmd_code : code_reg;
    wr_tgl_next   = wr_tgl_reg ^ sram_wr_stb;
    wake_tgl_next = wake_tgl_reg ^ addr_match_stb;
  end

  always_ff @(posedge scl or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cmd_tgl_reg  <= 1'b0;
      code_reg     <= 2'h0;
      wr_tgl_reg   <= 1'b0;
      wake_tgl_reg <= 1'b0;
    end else begin
      cmd_tgl_reg  <= cmd_tgl_next;
      code_reg     <= code_next;
      wr_tgl_reg   <= wr_tgl_next;
      wake_tgl_reg <= wake_tgl_next;
    end
  end

  assign link.cmd_tgl   = cmd_tgl_reg;
  assign link.cmd_code  = code_reg;
  assign link.write_tgl = wr_tgl_reg;
  assign link.wake_tgl  = wake_tgl_reg;

endmodule
`default_nettype wire

/* core/nvs_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_seq #(
  parameter int  PUREC_CYC    = nvs_pkg::POWERUP_RESTORE_CYC,
  parameter int  SAVE_CYC     = nvs_pkg::SAVE_CYCLE_CYC,
  parameter int  SLEEP_IN_CYC = nvs_pkg::SLEEP_ENTRY_CYC,
  parameter int  WAKE_CYC     = nvs_pkg::SLEEP_EXIT_CYC,
  parameter int  RECALL_CYC   = nvs_pkg::SOFT_RESTORE_CYC,
  parameter int  SOFTCMD_CYC  = nvs_pkg::SOFT_COMMAND_CYC,
  parameter bit  AUTOSAVE_EN  = 1'b1
) (
  // core clock and supply-good reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // link clock and decoded protocol strobes
  input  wire logic       scl,
  input  wire logic       cmd_stb,
  input  wire logic [1:0] cmd_code,
  input  wire logic       sram_wr_stb,
  input  wire logic       addr_match_stb,
  // pin levels
  input  wire logic       bus_idle,
  input  wire logic       power_fail,
  // nonvolatile array
  input  wire logic       nv_done,
  output logic            nv_save_req,
  output logic            nv_recall_req,
  // status and gating
  output logic            bus_access_en,
  output logic            sram_write_en,
  output logic            busy,
  output logic            low_power,
  output logic            standby
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int CW = nvs_pkg::CNT_W;
  if (PUREC_CYC < 1 || PUREC_CYC >= (1 << CW) || SAVE_CYC < 1 || SAVE_CYC >= (1 << CW) ||
      SLEEP_IN_CYC < 1 || SLEEP_IN_CYC >= (1 << CW) || WAKE_CYC < 1 ||
      WAKE_CYC >= (1 << CW) || RECALL_CYC < 1 || RECALL_CYC >= (1 << CW) ||
      SOFTCMD_CYC < 4) begin : g_bad_count
    $error("nvs_seq: cycle count out of range");
  end
  if (nvs_pkg::STANDBY_LAT_CYC > nvs_pkg::STANDBY_ENTRY_CYC ||
      nvs_pkg::STANDBY_LAT_CYC > 7) begin : g_bad_stby
    $error("nvs_seq: standby latency too long");
  end

  function automatic logic [CW-1:0] lim(input int n);
    return CW'(n - 1);
  endfunction

  // ----------------------------------------------------------------
  // reset release and synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n;
  logic [1:0] pf_sync_reg;
  logic [1:0] idle_sync_reg;
  logic [1:0] cmd_sync_reg;
  logic [1:0] wr_sync_reg;
  logic [1:0] wake_sync_reg;
  logic       cmd_seen_reg;
  logic       wr_seen_reg;
  logic       wake_seen_reg;

  nvs_link_if link ();

  nvs_link_side u_link (
    .scl            (scl),
    .reset_n        (reset_n),
    .cmd_stb        (cmd_stb),
    .cmd_code       (cmd_code),
    .sram_wr_stb    (sram_wr_stb),
    .addr_match_stb (addr_match_stb),
    .link           (link)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_sync_reg   <= 2'h0;
      idle_sync_reg <= 2'h0;
      cmd_sync_reg  <= 2'h0;
      wr_sync_reg   <= 2'h0;
      wake_sync_reg <= 2'h0;
      cmd_seen_reg  <= 1'b0;
      wr_seen_reg   <= 1'b0;
      wake_seen_reg <= 1'b0;
    end else begin
      pf_sync_reg   <= {pf_sync_reg[0], power_fail};
      idle_sync_reg <= {idle_sync_reg[0], bus_idle};
      cmd_sync_reg  <= {cmd_sync_reg[0], link.cmd_tgl};
      wr_sync_reg   <= {wr_sync_reg[0], link.write_tgl};
      wake_sync_reg <= {wake_sync_reg[0], link.wake_tgl};
      cmd_seen_reg  <= cmd_sync_reg[1];
      wr_seen_reg   <= wr_sync_reg[1];
      wake_seen_reg <= wake_sync_reg[1];
    end
  end

  // code is stable by the time its toggle has crossed
  logic       cmd_ev;
  logic       wr_ev;
  logic       wake_ev;
  logic       pf;
  logic       idle;
  assign cmd_ev  = cmd_sync_reg[1] ^ cmd_seen_reg;
  assign wr_ev   = wr_sync_reg[1] ^ wr_seen_reg;
  assign wake_ev = wake_sync_reg[1] ^ wake_seen_reg;
  assign pf      = pf_sync_reg[1];
  assign idle    = idle_sync_reg[1];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam int SBL = nvs_pkg::STANDBY_LAT_CYC;

  nvs_pkg::nvs_state_t state_reg;
  nvs_pkg::nvs_state_t state_next;
  logic [CW-1:0]       cnt_reg;
  logic [CW-1:0]       cnt_next;
  logic                dirty_reg;
  logic                dirty_next;
  logic [2:0]          idle_cnt_reg;
  logic [2:0]          idle_cnt_next;
  logic                save_req_reg;
  logic                save_req_next;
  logic                recall_req_reg;
  logic                recall_req_next;
  logic                access_reg;
  logic                access_next;
  logic                wr_en_reg;
  logic                wr_en_next;
  logic                busy_reg;
  logic                busy_next;
  logic                low_power_reg;
  logic                low_power_next;
  logic                standby_reg;
  logic                standby_next;

  // clean array on supply loss: nothing to save, go straight down
  function automatic nvs_pkg::nvs_state_t fail_to(input logic dirty);
    return (AUTOSAVE_EN && dirty) ? nvs_pkg::ST_GRACE : nvs_pkg::ST_DOWN;
  endfunction

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    // writes only count while access is open
    dirty_next = dirty_reg | (wr_ev && state_reg == nvs_pkg::ST_READY);
    case (state_reg)
      nvs_pkg::ST_PUREC: begin
        if (pf) begin
          state_next = nvs_pkg::ST_DOWN;
        end else if (nv_done || cnt_reg == lim(PUREC_CYC)) begin
          state_next = nvs_pkg::ST_READY;
          dirty_next = 1'b0;
        end
      end
      nvs_pkg::ST_READY: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (cmd_ev) begin
          case (link.cmd_code)
            nvs_pkg::CMD_SAVE: begin
              state_next = nvs_pkg::ST_SAVE;
            end
            nvs_pkg::CMD_RECALL: begin
              state_next = nvs_pkg::ST_RECALL;
            end
            nvs_pkg::CMD_SLEEP: begin
              state_next = nvs_pkg::ST_SLEEP_IN;
            end
            default: begin
              state_next = nvs_pkg::ST_READY;
            end
          endcase
        end
      end
      nvs_pkg::ST_SAVE: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (nv_done || cnt_reg == lim(SAVE_CYC)) begin
          state_next = nvs_pkg::ST_READY;
          dirty_next = 1'b0;
        end
      end
      nvs_pkg::ST_RECALL: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (nv_done || cnt_reg == lim(RECALL_CYC)) begin
          state_next = nvs_pkg::ST_READY;
          dirty_next = 1'b0;
        end
      end
      nvs_pkg::ST_SLEEP_IN: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (!dirty_reg || nv_done || cnt_reg == lim(SLEEP_IN_CYC)) begin
          state_next = nvs_pkg::ST_SLEEP;
          dirty_next = dirty_reg & ~nv_done;
        end
      end
      nvs_pkg::ST_SLEEP: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (wake_ev) begin
          state_next = nvs_pkg::ST_WAKE;
        end
      end
      nvs_pkg::ST_WAKE: begin
        if (pf) begin
          state_next = fail_to(dirty_next);
        end else if (cnt_reg == lim(WAKE_CYC)) begin
          state_next = nvs_pkg::ST_READY;
        end
      end
      nvs_pkg::ST_GRACE: begin
        // pending write finishes before the array is touched
        if (cnt_reg == lim(nvs_pkg::WRITE_GRACE_CYC)) begin
          state_next = nvs_pkg::ST_AUTO;
        end
      end
      nvs_pkg::ST_AUTO: begin
        if (nv_done || cnt_reg == lim(SAVE_CYC)) begin
          state_next = nvs_pkg::ST_DOWN;
          dirty_next = 1'b0;
        end
      end
      nvs_pkg::ST_DOWN: begin
        state_next = nvs_pkg::ST_DOWN;
      end
      default: begin
        state_next = nvs_pkg::ST_PUREC;
      end
    endcase
    if (state_next != state_reg) begin
      cnt_next = CW'(0);
    end
    if (!idle) begin
      idle_cnt_next = 3'h0;
    end else if (idle_cnt_reg == 3'(SBL)) begin
      idle_cnt_next = idle_cnt_reg;
    end else begin
      idle_cnt_next = idle_cnt_reg + 3'h1;
    end
    save_req_next   = state_next == nvs_pkg::ST_SAVE || state_next == nvs_pkg::ST_AUTO ||
                      (state_next == nvs_pkg::ST_SLEEP_IN && dirty_next);
    recall_req_next = state_next == nvs_pkg::ST_PUREC || state_next == nvs_pkg::ST_RECALL;
    access_next     = state_next == nvs_pkg::ST_READY;
    wr_en_next      = state_next == nvs_pkg::ST_READY || state_next == nvs_pkg::ST_GRACE;
    busy_next       = !(state_next == nvs_pkg::ST_READY || state_next == nvs_pkg::ST_SLEEP);
    low_power_next  = state_next == nvs_pkg::ST_SLEEP;
    standby_next    = state_next == nvs_pkg::ST_READY && idle &&
                      idle_cnt_reg == 3'(SBL);
  end

  // busy from reset: nothing is served until the restore has run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= nvs_pkg::ST_PUREC;
      cnt_reg        <= CW'(0);
      dirty_reg      <= 1'b0;
      idle_cnt_reg   <= 3'h0;
      save_req_reg   <= 1'b0;
      recall_req_reg <= 1'b0;
      access_reg     <= 1'b0;
      wr_en_reg      <= 1'b0;
      busy_reg       <= 1'b1;
      low_power_reg  <= 1'b0;
      standby_reg    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      dirty_reg      <= dirty_next;
      idle_cnt_reg   <= idle_cnt_next;
      save_req_reg   <= save_req_next;
      recall_req_reg <= recall_req_next;
      access_reg     <= access_next;
      wr_en_reg      <= wr_en_next;
      busy_reg       <= busy_next;
      low_power_reg  <= low_power_next;
      standby_reg    <= standby_next;
    end
  end

  assign nv_save_req   = save_req_reg;
  assign nv_recall_req = recall_req_reg;
  assign bus_access_en = access_reg;
  assign sram_write_en = wr_en_reg;
  assign busy          = busy_reg;
  assign low_power     = low_power_reg;
  assign standby       = standby_reg;

endmodule
`default_nettype wire

/* bench/nvs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_props #(
  parameter int PUREC_CYC = 40,
  parameter int WAKE_CYC  = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and status
  input wire logic bus_idle,
  input wire logic power_fail,
  input wire logic nv_save_req,
  input wire logic nv_recall_req,
  input wire logic bus_access_en,
  input wire logic busy,
  input wire logic low_power,
  input wire logic standby
);
  // slack covers the two-flop crossings
  localparam int PU_MAX = PUREC_CYC + 8;
  localparam int WK_MAX = WAKE_CYC + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_restore_bound: assert property ($rose(reset_n) |-> ##[1:PU_MAX] !busy)
    else $error("restore too slow");
  a_busy_locks: assert property (busy |-> !bus_access_en)
    else $error("access while busy");
  a_low_supply: assert property (power_fail [*4] |-> !bus_access_en)
    else $error("access on low supply");
  a_save_locks: assert property (nv_save_req |-> busy)
    else $error("save without lock");
  a_recall_locks: assert property (nv_recall_req |-> busy)
    else $error("restore without lock");
  a_sleep_quiet: assert property (low_power |-> !bus_access_en && !nv_save_req)
    else $error("activity in sleep");
  a_wake_bound: assert property ($fell(low_power) |-> ##[0:WK_MAX] bus_access_en)
    else $error("wake too slow");
  a_standby_idle: assert property ((bus_idle && bus_access_en) [*8] |-> standby)
    else $error("no standby");
  cover property ($rose(low_power));
  cover property ($rose(nv_save_req));
  cover property ($fell(standby));
endmodule
bind nvs_seq nvs_props #(.PUREC_CYC(PUREC_CYC), .WAKE_CYC(WAKE_CYC)) nvs_props_inst (.*);
`default_nettype wire

/* bench/nvs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module nvs_host (
  // link clock and bus level
  output logic       scl,
  output logic       bus_idle,
  // decoded strobes
  output logic       cmd_stb,
  output logic [1:0] cmd_code,
  output logic       sram_wr_stb,
  output logic       addr_match_stb
);
  // scl is pulled up, so it stands high between frames
  initial begin
    scl = 1'b1;
    bus_idle = 1'b1;
    {cmd_stb, sram_wr_stb, addr_match_stb} = 3'h0;
    cmd_code = 2'h3;
  end
  task automatic tick();
    #15 scl = 1'b0;
    #15 scl = 1'b1;
  endtask
  // kind 0 write, 1 soft command, 2 address match
  task automatic frame(input int kind, input logic [1:0] code);
    #15;
    bus_idle = 1'b0;
    repeat (8) tick();
    #5;
    {sram_wr_stb, cmd_stb, addr_match_stb} = {kind == 0, kind == 1, kind == 2};
    cmd_code = code;
    tick();
    #5;
    {sram_wr_stb, cmd_stb, addr_match_stb} = 3'h0;
    cmd_code = ~code;
    tick();
    bus_idle = 1'b1;
  endtask
endmodule
`default_nettype wire

/* bench/test_nvs_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, g) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_nvs_seq;
  localparam int PU = 40;
  localparam int SV = 30;
  localparam int RC = 20;
  localparam int SL = 20;
  localparam int WK = 40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_fail = 1'b0;
  logic nv_done = 1'b0;
  logic scl, cmd_stb, sram_wr_stb, addr_match_stb, bus_idle;
  logic [1:0] cmd_code;
  logic nv_save_req, nv_recall_req, bus_access_en, sram_write_en, busy, low_power, standby;
  logic [4:0] outs;
  logic [2:0] exp_q[$];
  logic [2:0] exp_v;
  string what;
  event chk;
  int mismatches = 0;
  int n_checks = 0;
  int n_save = 0;
  int base;
  int dly = 0;
  int seed = 32'hb76f0337;
  nvs_host nvs_host_inst (.*);
  nvs_seq #(.PUREC_CYC(PU), .SAVE_CYC(SV), .SLEEP_IN_CYC(SL), .WAKE_CYC(WK),
    .RECALL_CYC(RC), .SOFTCMD_CYC(10)) nvs_seq_inst (.*);
  assign outs = {nv_save_req, bus_access_en, standby, low_power, busy};
  always #12.5 clk = ~clk;
  // array answers after a random delay
  always @(posedge clk) begin
    nv_done <= 1'b0;
    if (!(nv_save_req || nv_recall_req)) dly <= 2 + {$random(seed)} % 6;
    else if (dly > 0) dly <= dly - 1;
    else nv_done <= 1'b1;
  end
  always @(posedge nv_save_req) n_save++;
  always @chk begin
    exp_v = exp_q.pop_front();
    `CMP(what, exp_v, {bus_access_en, busy, low_power})
  end
  task automatic await(input int i, input logic v, input int lim, input string n);
    int k;
    k = 0;
    while (outs[i] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    `CMP(n, v, outs[i])
  endtask
  task automatic note(input string n, input logic [2:0] e);
    @(negedge clk);
    what = n;
    exp_q.push_back(e);
    ->chk;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    await(0, 1'b0, PU + 8, "restore");
    note("ready", 3'b100);
    `CMP("write gate", 1'b1, sram_write_en)
    await(2, 1'b1, 12, "standby");
    $display("test restore done");
    for (int j = 0; j < 2; j++) begin
      nvs_host_inst.frame(0, 2'h0);
      nvs_host_inst.frame(1, j ? nvs_pkg::CMD_RECALL : nvs_pkg::CMD_SAVE);
      await(0, 1'b1, 18, "taken");
      note("locked", 3'b010);
      `CMP("write shut", 1'b0, sram_write_en)
      `CMP("restore req", 1'(j), nv_recall_req)
      await(0, 1'b0, (j ? RC : SV) + 8, "ended");
      await(2, 1'b1, 12, "standby");
      $display("test command %0d done", j);
    end
    nvs_host_inst.frame(1, nvs_pkg::CMD_SLEEP);
    await(1, 1'b1, SL + 8, "sleep");
    nvs_host_inst.frame(2, 2'h0);
    await(3, 1'b1, WK + 8, "wake");
    note("awake", 3'b100);
    $display("test sleep done");
    base = n_save;
    @(posedge clk);
    power_fail <= 1'b1;
    await(3, 1'b0, 4, "cut off");
    repeat (20) @(negedge clk);
    `CMP("skip", base, n_save)
    @(posedge clk);
    reset_n <= 1'b0;
    power_fail <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    await(0, 1'b0, PU + 8, "restore");
    repeat (1 + {$random(seed)} % 3) nvs_host_inst.frame(0, 2'h0);
    @(posedge clk);
    power_fail <= 1'b1;
    await(4, 1'b1, 8, "auto save");
    $display("test power fail done");
    results();
  end
  initial begin
    #150000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
